// ### logic/cswa_pkg.sv
// Shared constants and types for the status word and add/logic slice
package cswa_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_GPR0 = 8'h00;
    localparam logic [7:0] ADDR_PC   = 8'h40;
    localparam logic [7:0] ADDR_SSP  = 8'h44;
    localparam logic [7:0] ADDR_SW   = 8'h48;
    localparam logic [7:0] ADDR_SFC  = 8'h4C;
    localparam logic [7:0] ADDR_DFC  = 8'h50;
    localparam logic [7:0] ADDR_VBR  = 8'h54;
    localparam logic [7:0] ADDR_CMD  = 8'h58;
    localparam logic [7:0] ADDR_OPND = 8'h5C;
    localparam logic [7:0] ADDR_EXT  = 8'h60;
    localparam logic [7:0] ADDR_EA   = 8'h64;
    localparam logic [7:0] ADDR_RES  = 8'h68;
    localparam logic [7:0] ADDR_STAT = 8'h6C;
    // Status word layout
    localparam int SW_S      = 13;
    localparam int SW_MLO    = 8;
    localparam int FLAG_X    = 4;
    localparam int FLAG_N    = 3;
    localparam int FLAG_Z    = 2;
    localparam int FLAG_V    = 1;
    localparam int FLAG_C    = 0;
    localparam logic [15:0] SW_RESET = 16'h2700;
    localparam logic [15:0] SW_IMPL  = 16'hE71F;
    localparam logic [7:0]  FL_IMPL  = 8'h1F;
    localparam logic [2:0]  LVL_NMI  = 3'h7;
    // Command word fields
    localparam int CMD_OP  = 0;
    localparam int CMD_SZ  = 4;
    localparam int CMD_EAR = 6;
    localparam int CMD_DR  = 9;
    localparam int CMD_MD  = 12;
    localparam int CMD_XR  = 16;
    localparam int CMD_TOEA = 19;
    // Status bits: sticky error flags, live pending flag
    localparam int ST_PRIV = 0;
    localparam int ST_ILL  = 1;
    localparam int ST_PEND = 2;

    typedef enum logic [3:0] {
        OP_SUM, OP_SUM_PTR, OP_SUM_LIT, OP_SUM_QUICK, OP_SUM_CARRY, OP_DEC_SUM,
        OP_CONJ, OP_CONJ_LIT, OP_CONJ_FLAGS, OP_CONJ_SW, OP_SW_TO_EA
    } cswa_op_t;
    typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L, SZ_BAD} cswa_size_t;
    typedef enum logic [3:0] {
        M_DREG, M_AREG, M_IND, M_POST, M_PRE, M_DISP, M_INDEX,
        M_PCDISP, M_PCIDX, M_ABS, M_IMM
    } cswa_mode_t;
endpackage

// ### logic/cswa_alu_if.sv
// Operand and result bundle between the core and its adder/logic unit
`timescale 1ns/1ps
interface cswa_alu_if;
    import cswa_pkg::*;
    cswa_op_t    op;
    cswa_size_t  size;
    logic [31:0] a;
    logic [31:0] b;
    logic [4:0]  flagsIn;
    logic [31:0] res;
    logic [4:0]  flagsOut;
    modport core (output op, size, a, b, flagsIn, input res, flagsOut);
    modport alu  (input op, size, a, b, flagsIn, output res, flagsOut);
endinterface

// ### logic/cswa_alu.sv
// Binary, extended and decimal adder plus conjunction with flag generation
`timescale 1ns/1ps
module cswa_alu
    import cswa_pkg::*;
(
    // Operands and results
    cswa_alu_if.alu bus
);
    logic [8:0]  s8;
    logic [16:0] s16;
    logic [32:0] s32;
    logic [31:0] full;
    logic [31:0] srcX;
    logic [4:0]  lo;
    logic [4:0]  hi;
    logic        loC;
    logic        hiC;
    logic        cin;
    logic        cy;
    logic        mA;
    logic        mB;
    logic        mR;
    logic        isZ;

    always_comb begin
        cin  = (bus.op == OP_SUM_CARRY) && bus.flagsIn[FLAG_X];
        s8   = {1'b0, bus.a[7:0]} + {1'b0, bus.b[7:0]} + {8'h00, cin};
        s16  = {1'b0, bus.a[15:0]} + {1'b0, bus.b[15:0]} + {16'h0000, cin};
        s32  = {1'b0, bus.a} + {1'b0, bus.b} + {32'h0, cin};
        // Decimal digits, low then high with nibble carry
        lo   = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.flagsIn[FLAG_X]};
        loC  = lo > 5'h09;
        if (loC) begin
            lo = lo + 5'h06;
        end
        hi   = {1'b0, bus.a[7:4]} + {1'b0, bus.b[7:4]} + {4'h0, loC};
        hiC  = hi > 5'h09;
        if (hiC) begin
            hi = hi + 5'h06;
        end
        srcX = (bus.size == SZ_W) ? {{16{bus.a[15]}}, bus.a[15:0]} : bus.a;
        case (bus.op)
            OP_CONJ, OP_CONJ_LIT: full = bus.a & bus.b;
            OP_DEC_SUM:           full = {24'h000000, hi[3:0], lo[3:0]};
            default:              full = s32[31:0];
        endcase
        // Upper destination bits survive narrow operations other than the pointer add
        unique case (bus.size)
            SZ_B: begin
                mA  = bus.a[7];
                mB  = bus.b[7];
                mR  = full[7];
                cy  = s8[8];
                isZ = full[7:0] == 8'h00;
                bus.res = {bus.b[31:8], full[7:0]};
            end
            SZ_W: begin
                mA  = bus.a[15];
                mB  = bus.b[15];
                mR  = full[15];
                cy  = s16[16];
                isZ = full[15:0] == 16'h0000;
                bus.res = {bus.b[31:16], full[15:0]};
            end
            default: begin
                mA  = bus.a[31];
                mB  = bus.b[31];
                mR  = full[31];
                cy  = s32[32];
                isZ = full == 32'h0;
                bus.res = full;
            end
        endcase
        bus.flagsOut = bus.flagsIn;
        case (bus.op)
            OP_SUM_PTR: begin
                bus.res = bus.b + srcX;
            end
            OP_CONJ, OP_CONJ_LIT: begin
                bus.flagsOut[FLAG_N] = mR;
                bus.flagsOut[FLAG_Z] = isZ;
                bus.flagsOut[FLAG_V] = 1'b0;
                bus.flagsOut[FLAG_C] = 1'b0;
            end
            OP_DEC_SUM: begin
                bus.flagsOut[FLAG_X] = hiC;
                bus.flagsOut[FLAG_C] = hiC;
                if (!isZ) begin
                    bus.flagsOut[FLAG_Z] = 1'b0;
                end
            end
            default: begin
                bus.flagsOut[FLAG_X] = cy;
                bus.flagsOut[FLAG_C] = cy;
                bus.flagsOut[FLAG_N] = mR;
                bus.flagsOut[FLAG_V] = (mA == mB) && (mR != mA);
                // Zero only clears under carry-in so multi-word sums chain
                if (bus.op != OP_SUM_CARRY || !isZ) begin
                    bus.flagsOut[FLAG_Z] = isZ && (bus.op != OP_SUM_CARRY);
                end
            end
        endcase
    end
endmodule

// ### logic/cswa_core.sv
// Programming-model registers, status word and add/logic execute over APB
`timescale 1ns/1ps
// Function
// - Keep 16 general, pc, supervisor stack, status, two function-code, vector base registers.
// - The privilege bit picks supervisor or user level; user level refuses privileged work.
// - User level sees only the flag byte of the status word, supervisor level the whole word.
// - Copying the full status word elsewhere at user level is refused as a privilege violation.
// - Status word holds trace bits 15:14, privilege 13, mask 10:8 and flags X N Z V C at 4:0.
// - Status word bits 7:5 and 12:11 read zero and ignore writes.
// - Operands are decimal bytes and 8, 16, 32 bit words; 64-bit sums chain two adds.
// - Modes: direct, indirect, post-inc, pre-dec, offset, index, pc, absolute, immediate.
// - Decimal add sums two decimal bytes and extend, as register or predecremented memory pairs.
// - Add works in 8, 16, 32 bits to data register or memory; the pointer form not in 8.
// - Literal and short-literal adds add a constant to the destination and write it back.
// - Carry-in add sums source, destination and extend over register or predecrement pairs.
// - Conjunction combines source or literal with the destination and writes it back.
// - Mask blocks request levels at or below it except level seven, and zero blocks nothing.
// - Taking an interrupt loads the mask with the serviced level.
module cswa_core
    import cswa_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt requests
    input  wire logic [2:0]  irqLevel,
    input  wire logic        irqTake,
    output logic             irqPending,
    // Core state
    output logic             supervisor,
    output logic [2:0]       intMask
);
    typedef struct packed {
        logic [15:0][31:0] gpr;
        logic [31:0]       pc;
        logic [31:0]       ssp;
        logic [31:0]       vbr;
        logic [2:0]        sfc;
        logic [2:0]        dfc;
        logic [15:0]       sw;
        logic [31:0]       opnd;
        logic [31:0]       ext;
        logic [31:0]       ea;
        logic [31:0]       result;
        logic              privErr;
        logic              illErr;
        logic [31:0]       rdata;
    } cswa_state_t;

    localparam cswa_state_t ST_RESET = '{sw: SW_RESET, default: '0};

    cswa_state_t s;
    cswa_state_t n;
    cswa_alu_if  aluBus ();

    cswa_op_t    cOp;
    cswa_size_t  cSz;
    cswa_mode_t  cMd;
    logic [3:0]  cEaR;
    logic [2:0]  cDr;
    logic [2:0]  cXr;
    logic        cToEa;
    logic        wrEn;
    logic        isCmd;
    logic        toEa;
    logic        bad;
    logic        priv;
    logic        pend;
    logic [31:0] step;
    logic [31:0] anVal;
    logic [31:0] dEa;
    logic [31:0] dReg;
    logic [31:0] xVal;
    logic [31:0] d16;
    logic [31:0] d8;
    logic [31:0] eaAddr;
    logic [31:0] newAn;
    logic [31:0] eaVal;
    logic [31:0] wrVal;
    logic [31:0] dstA;

    cswa_alu u_alu (
        .bus (aluBus)
    );

    // Address register seven is the supervisor stack while privileged
    function automatic logic [31:0] getReg(cswa_state_t t, logic [3:0] i);
        return (i == 4'hF && t.sw[SW_S]) ? t.ssp : t.gpr[i];
    endfunction

    function automatic cswa_state_t putReg(cswa_state_t t, logic [3:0] i,
                                           logic [31:0] v);
        if (i == 4'hF && t.sw[SW_S]) begin
            t.ssp = v;
        end else begin
            t.gpr[i] = v;
        end
        return t;
    endfunction

    function automatic logic mapped(logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= ADDR_STAT);
    endfunction

    function automatic logic [31:0] rdMux(cswa_state_t t, logic [7:0] a, logic p);
        logic [31:0] v;
        v = 32'h0;
        if (a < ADDR_PC) begin
            v = t.gpr[a[5:2]];
        end else begin
            case (a)
                ADDR_PC:   v = t.pc;
                ADDR_SSP:  v = t.ssp;
                ADDR_SW:   v = t.sw[SW_S] ? {16'h0000, t.sw} : {24'h0, t.sw[7:0]};
                ADDR_SFC:  v = {29'h0, t.sfc};
                ADDR_DFC:  v = {29'h0, t.dfc};
                ADDR_VBR:  v = t.vbr;
                ADDR_OPND: v = t.opnd;
                ADDR_EXT:  v = t.ext;
                ADDR_EA:   v = t.ea;
                ADDR_RES:  v = t.result;
                ADDR_STAT: v = {29'h0, p, t.illErr, t.privErr};
                default:   v = 32'h0;
            endcase
        end
        return v;
    endfunction

    always_comb begin
        n     = s;
        cOp   = cswa_op_t'(pwdata[CMD_OP +: 4]);
        cSz   = cswa_size_t'(pwdata[CMD_SZ +: 2]);
        cMd   = cswa_mode_t'(pwdata[CMD_MD +: 4]);
        cEaR  = {1'b1, pwdata[CMD_EAR +: 3]};
        cDr   = pwdata[CMD_DR +: 3];
        cXr   = pwdata[CMD_XR +: 3];
        cToEa = pwdata[CMD_TOEA];
        wrEn  = psel && penable && pwrite;
        isCmd = wrEn && (paddr == ADDR_CMD);
        // Mask zero passes all, level seven always passes
        pend  = (irqLevel == LVL_NMI) || (irqLevel > s.sw[SW_MLO +: 3]);
        anVal = getReg(s, cEaR);
        dEa   = getReg(s, {1'b0, cEaR[2:0]});
        dReg  = getReg(s, {1'b0, cDr});
        xVal  = getReg(s, {1'b0, cXr});
        d16   = {{16{s.ext[15]}}, s.ext[15:0]};
        d8    = {{24{s.ext[7]}}, s.ext[7:0]};
        // Byte steps keep the stack pointer word aligned when cEaR selects it
        unique case (cSz)
            SZ_B:    step = (cEaR == 4'hF) ? 32'h2 : 32'h1;
            SZ_W:    step = 32'h2;
            default: step = 32'h4;
        endcase
        eaAddr = 32'h0;
        newAn  = anVal;
        unique case (cMd)
            M_IND:    eaAddr = anVal;
            M_POST: begin
                eaAddr = anVal;
                newAn  = anVal + step;
            end
            M_PRE: begin
                eaAddr = anVal - step;
                newAn  = eaAddr;
            end
            M_DISP:   eaAddr = anVal + d16;
            M_INDEX:  eaAddr = anVal + d8 + xVal;
            M_PCDISP: eaAddr = s.pc + d16;
            M_PCIDX:  eaAddr = s.pc + d8 + xVal;
            M_ABS:    eaAddr = s.ext;
            default:  eaAddr = 32'h0;
        endcase
        case (cMd)
            M_DREG:  eaVal = dEa;
            M_AREG:  eaVal = anVal;
            M_IMM:   eaVal = s.ext;
            default: eaVal = s.opnd;
        endcase
        // Operand routing per operation
        aluBus.op      = cOp;
        aluBus.size    = cSz;
        aluBus.a       = eaVal;
        aluBus.b       = dReg;
        aluBus.flagsIn = s.sw[4:0];
        toEa = 1'b0;
        priv = 1'b0;
        bad  = (cSz == SZ_BAD) || (cMd > M_IMM);
        case (cOp)
            OP_SUM, OP_CONJ: begin
                if (cToEa) begin
                    aluBus.a = dReg;
                    aluBus.b = eaVal;
                    toEa     = 1'b1;
                end
            end
            OP_SUM_PTR: begin
                aluBus.b = getReg(s, {1'b1, cDr});
                bad      = bad || (cSz == SZ_B);
            end
            OP_SUM_LIT, OP_CONJ_LIT: begin
                aluBus.a = s.ext;
                aluBus.b = eaVal;
                toEa     = 1'b1;
            end
            OP_SUM_QUICK: begin
                aluBus.a = {28'h0, cDr == 3'h0, cDr};
                aluBus.b = eaVal;
                toEa     = 1'b1;
                if (cMd == M_AREG) begin
                    aluBus.op   = OP_SUM_PTR;
                    aluBus.size = SZ_L;
                end
            end
            OP_SUM_CARRY, OP_DEC_SUM: begin
                if (cMd == M_PRE) begin
                    aluBus.a = s.ext;
                    aluBus.b = s.opnd;
                end else begin
                    aluBus.a = dEa;
                end
                if (cOp == OP_DEC_SUM) begin
                    aluBus.size = SZ_B;
                end
                bad = bad || !(cMd == M_DREG || cMd == M_PRE);
            end
            OP_CONJ_SW, OP_SW_TO_EA: begin
                priv     = !s.sw[SW_S];
                aluBus.b = eaVal;
                toEa     = (cOp == OP_SW_TO_EA);
            end
            OP_CONJ_FLAGS: begin
                bad = bad && 1'b0;
            end
            default: bad = 1'b1;
        endcase
        // Relative and literal forms cannot be written
        bad   = bad || (toEa && cMd >= M_PCDISP && cMd != M_ABS);
        wrVal = (cOp == OP_SW_TO_EA) ? {aluBus.b[31:16], s.sw} : aluBus.res;
        dstA  = 32'h0;
        // Register writes from the bus
        if (wrEn) begin
            if (paddr < ADDR_PC) begin
                n.gpr[paddr[5:2]] = pwdata;
            end else begin
                case (paddr)
                    ADDR_PC:   n.pc = pwdata;
                    ADDR_SSP:  n.ssp = s.sw[SW_S] ? pwdata : s.ssp;
                    ADDR_SW: begin
                        if (s.sw[SW_S]) begin
                            n.sw = pwdata[15:0] & SW_IMPL;
                        end else begin
                            n.sw[7:0] = pwdata[7:0] & FL_IMPL;
                        end
                    end
                    ADDR_SFC:  n.sfc = s.sw[SW_S] ? pwdata[2:0] : s.sfc;
                    ADDR_DFC:  n.dfc = s.sw[SW_S] ? pwdata[2:0] : s.dfc;
                    ADDR_VBR:  n.vbr = s.sw[SW_S] ? pwdata : s.vbr;
                    ADDR_OPND: n.opnd = pwdata;
                    ADDR_EXT:  n.ext = pwdata;
                    ADDR_STAT: begin
                        n.privErr = s.privErr && !pwdata[ST_PRIV];
                        n.illErr  = s.illErr && !pwdata[ST_ILL];
                    end
                    default: n.rdata = s.rdata;
                endcase
            end
            if (!s.sw[SW_S] && (paddr == ADDR_SSP || paddr == ADDR_SFC
                                || paddr == ADDR_DFC || paddr == ADDR_VBR)) begin
                n.privErr = 1'b1;
            end
        end
        // Command execution; error sets win over a same-cycle clear
        if (isCmd && priv) begin
            n.privErr = 1'b1;
        end else if (isCmd && bad) begin
            n.illErr = 1'b1;
        end else if (isCmd) begin
            if (cOp == OP_CONJ_FLAGS) begin
                n.sw[7:0] = s.sw[7:0] & s.ext[7:0] & FL_IMPL;
            end else if (cOp == OP_CONJ_SW) begin
                n.sw = s.sw & s.ext[15:0] & SW_IMPL;
            end else if (cOp != OP_SW_TO_EA) begin
                n.sw[4:0] = aluBus.flagsOut;
            end
            if (cMd == M_POST || cMd == M_PRE) begin
                n = putReg(n, cEaR, newAn);
            end
            if ((cOp == OP_SUM_CARRY || cOp == OP_DEC_SUM) && cMd == M_PRE) begin
                // Destination pointer decremented after source, same register twice
                dstA     = getReg(n, {1'b1, cDr}) - step;
                n        = putReg(n, {1'b1, cDr}, dstA);
                n.ea     = dstA;
                n.result = wrVal;
            end else if (toEa) begin
                case (cMd)
                    M_DREG:  n = putReg(n, {1'b0, cEaR[2:0]}, wrVal);
                    M_AREG:  n = putReg(n, cEaR, wrVal);
                    default: begin
                        n.ea     = eaAddr;
                        n.result = wrVal;
                    end
                endcase
            end else if (cOp == OP_SUM_PTR) begin
                n = putReg(n, {1'b1, cDr}, wrVal);
            end else if (cOp != OP_CONJ_FLAGS && cOp != OP_CONJ_SW) begin
                n = putReg(n, {1'b0, cDr}, wrVal);
            end
        end
        // Interrupt acceptance overrides a same-cycle mask write
        if (irqTake) begin
            n.sw[SW_MLO +: 3] = irqLevel;
        end
        if (psel && !penable && !pwrite) begin
            n.rdata = rdMux(s, paddr, pend);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= ST_RESET;
        end else begin
            s <= n;
        end
    end

    assign prdata     = s.rdata;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped(paddr);
    assign irqPending = pend;
    assign supervisor = s.sw[SW_S];
    assign intMask    = s.sw[SW_MLO +: 3];
endmodule

// ### verif/cswa_checker.sv
// Port-level properties of the status word and add/logic core
`timescale 1ns/1ps
module cswa_checker
    import cswa_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupts and state
    input wire logic [2:0]  irqLevel,
    input wire logic        irqTake,
    input wire logic        irqPending,
    input wire logic        supervisor,
    input wire logic [2:0]  intMask
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Capture edge of a status word read with no mask load racing it
    sequence swRead;
        psel && !penable && !pwrite && paddr == ADDR_SW && !irqTake;
    endsequence
    sequence svRead;
        swRead ##0 supervisor;
    endsequence
    sequence userRead;
        swRead ##0 !supervisor;
    endsequence
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    bad_addr_a: assert property (psel && penable
        && (paddr[1:0] != 2'h0 || paddr > ADDR_STAT) |-> pslverr)
        else $error("unmapped access without error");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    reset_word_a: assert property (disable iff (1'h0)
        !rstn |=> supervisor && intMask == 3'h7) else $error("reset did not load status word");
    mask_pend_a: assert property (irqPending
        == (irqLevel == LVL_NMI || irqLevel > intMask))
        else $error("pending flag disagrees with mask");
    mask_load_a: assert property (irqTake |=> intMask == $past(irqLevel))
        else $error("mask not loaded with serviced level");
    user_locked_a: assert property (!supervisor && !irqTake |=> !supervisor)
        else $error("user level left without exception");
    user_mask_a: assert property (!supervisor && !irqTake |=> $stable(intMask))
        else $error("mask changed at user level");
    user_read_a: assert property (userRead |=> prdata[31:5] == 27'h0)
        else $error("user read shows system byte");
    sv_read_a: assert property (svRead |=> prdata[13] == supervisor
        && prdata[10:8] == intMask && prdata[7:5] == 3'h0 && prdata[12:11] == 2'h0)
        else $error("status word read wrong");
endmodule

bind cswa_core cswa_checker cswa_checker_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irqLevel, .irqTake, .irqPending, .supervisor, .intMask);

// ### verif/cpu_status_word_and_add_logic_test.sv
// Self-checking bench for the status word and add/logic core
`timescale 1ns/1ps
module cpu_status_word_and_add_logic_test;
    import cswa_pkg::*;
    logic        clk = 1'h0;
    logic        rstn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  irqLevel = 3'h0;
    logic        irqTake = 1'h0;
    logic        irqPending;
    logic        supervisor;
    logic [2:0]  intMask;
    int          bad_count = 0;
    int          num_checks = 0;
    always #20 clk = ~clk;
    cswa_core cswa_core_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irqLevel, .irqTake, .irqPending, .supervisor, .intMask);
    task automatic finish_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle cycle after each transfer keeps every strobe single-driven per step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
        if (n >= 20) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'h1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        xfer(1'h0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task automatic sReset();
        logic [31:0] r;
        logic        e;
        rd(ADDR_SW, 32'h00002700);
        chk({28'h0, supervisor, intMask}, 32'hF);
        xfer(1'h0, 8'h70, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wr(ADDR_SW, 32'hFFFFFFFF);
        rd(ADDR_SW, 32'h0000E71F);
        wr(ADDR_SW, 32'h00002700);
    endtask
    task automatic sAdd();
        wr(8'h00, 32'h7FFFFFFF);
        wr(8'h04, 32'h00000001);
        wr(ADDR_CMD, 32'h00000220);
        rd(8'h04, 32'h80000000);
        rd(ADDR_SW, 32'h0000270A);
        wr(8'h00, 32'h0000FFFF);
        wr(8'h04, 32'h12345601);
        wr(ADDR_CMD, 32'h00000200);
        rd(8'h04, 32'h12345600);
        rd(ADDR_SW, 32'h00002715);
        wr(8'h28, 32'h00000010);
        wr(ADDR_CMD, 32'h00000411);
        rd(8'h28, 32'h0000000F);
        rd(ADDR_SW, 32'h00002715);
        wr(ADDR_CMD, 32'h00000401);
        rd(8'h28, 32'h0000000F);
        rd(ADDR_STAT, 32'h00000002);
        wr(ADDR_STAT, 32'h00000002);
    endtask
    task automatic sLiteral();
        wr(8'h0C, 32'h0001FFFC);
        wr(ADDR_CMD, 32'h000000D3);
        rd(8'h0C, 32'h00010004);
        rd(ADDR_SW, 32'h00002711);
        wr(ADDR_EXT, 32'h00000010);
        wr(ADDR_CMD, 32'h000000E2);
        rd(8'h0C, 32'h00010014);
    endtask
    task automatic sExtend();
        wr(ADDR_SW, 32'h00002714);
        wr(8'h10, 32'hFFFFFFFF);
        wr(8'h14, 32'h00000000);
        wr(ADDR_CMD, 32'h00000B24);
        rd(8'h14, 32'h00000000);
        rd(ADDR_SW, 32'h00002715);
        wr(ADDR_SW, 32'h00002714);
        wr(8'h18, 32'h00000058);
        wr(8'h1C, 32'hAB000047);
        wr(ADDR_CMD, 32'h00000F85);
        rd(8'h1C, 32'hAB000006);
        rd(ADDR_SW, 32'h00002711);
    endtask
    task automatic sConj();
        wr(ADDR_SW, 32'h00002713);
        wr(ADDR_EXT, 32'h0000800F);
        wr(ADDR_CMD, 32'h00000017);
        rd(8'h00, 32'h0000800F);
        rd(ADDR_SW, 32'h00002718);
        wr(ADDR_EXT, 32'h00000010);
        wr(ADDR_CMD, 32'h00000008);
        rd(ADDR_SW, 32'h00002710);
        wr(ADDR_EXT, 32'h0000F8FF);
        wr(ADDR_CMD, 32'h00000009);
        rd(ADDR_SW, 32'h00002010);
    endtask
    task automatic sIrq();
        irqLevel <= 3'h1;
        @(negedge clk);
        chk({31'h0, irqPending}, 32'h1);
        @(posedge clk);
        irqLevel <= 3'h3;
        wr(ADDR_SW, 32'h00002300);
        chk({31'h0, irqPending}, 32'h0);
        irqLevel <= 3'h7;
        wr(ADDR_SW, 32'h00002700);
        chk({31'h0, irqPending}, 32'h1);
        irqLevel <= 3'h5;
        irqTake <= 1'h1;
        @(posedge clk);
        irqTake <= 1'h0;
        irqLevel <= 3'h0;
        @(negedge clk);
        chk({29'h0, intMask}, 32'h5);
        // Next request must start after a rising edge
        @(posedge clk);
    endtask
    task automatic sMode();
        wr(ADDR_OPND, 32'h00000001);
        wr(ADDR_CMD, 32'h000832A0);
        rd(ADDR_EA, 32'h0000000F);
        rd(ADDR_RES, 32'h12345601);
        rd(8'h28, 32'h00000013);
        wr(ADDR_EXT, 32'h00000015);
        wr(ADDR_OPND, 32'h00000027);
        wr(ADDR_CMD, 32'h00004685);
        rd(ADDR_RES, 32'h00000042);
        rd(ADDR_EA, 32'hFFFFFFFF);
        rd(8'h28, 32'h00000012);
        wr(ADDR_CMD, 32'h0000901A);
        rd(ADDR_RES, 32'h00002500);
        rd(ADDR_EA, 32'h00000015);
    endtask
    task automatic sUser();
        wr(ADDR_SW, 32'h0000001F);
        chk({31'h0, supervisor}, 32'h0);
        rd(ADDR_SW, 32'h0000001F);
        wr(ADDR_SW, 32'hFFFF2700);
        rd(ADDR_SW, 32'h00000000);
        chk({28'h0, supervisor, intMask}, 32'h0);
        wr(ADDR_VBR, 32'h00000100);
        rd(ADDR_STAT, 32'h00000001);
        wr(ADDR_STAT, 32'h00000001);
        wr(ADDR_CMD, 32'h0000000A);
        rd(ADDR_STAT, 32'h00000001);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        sReset();
        sAdd();
        sLiteral();
        sExtend();
        sConj();
        sIrq();
        sMode();
        sUser();
        finish_test();
    end
endmodule
